// ===== logic/ptp_device.sv
// pwm control logic: pulse train interpretation and push-pull steering
`timescale 1ns/100ps
module ptp_device (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    ptp_link_if.device link,
    input wire logic ref_good_in,
    input wire logic pwm_trip_in,
    input wire logic current_trip_in,
    output logic drive_output_a,
    output logic drive_output_b,
    output logic [2:0] limit_threshold_out
);
    logic [1:0] pt_s_q, ref_s_q, pwm_s_q, cl_s_q;
    logic pt_last_q, pt_last_d;
    logic sel_q, sel_d;
    logic rdy_last_q, rdy_last_d;
    logic on_q, on_d;
    logic flag_q, flag_d;
    logic a_q, a_d, b_q, b_d;
    logic [2:0] thr_q, thr_d;
    logic rise, pt, ready;

    // two-stage synchronisers; only stage 2 is read by logic
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pt_s_q <= 2'h0;
            ref_s_q <= 2'h0;
            pwm_s_q <= 2'h0;
            cl_s_q <= 2'h0;
        end else begin
            pt_s_q <= {pt_s_q[0], link.pulse_train};
            ref_s_q <= {ref_s_q[0], ref_good_in};
            pwm_s_q <= {pwm_s_q[0], pwm_trip_in};
            cl_s_q <= {cl_s_q[0], current_trip_in};
        end
    end

    assign pt = pt_s_q[1];
    assign ready = ref_s_q[1];
    assign rise = pt & ~pt_last_q;

    always_comb begin
        pt_last_d = pt;
        rdy_last_d = ready;
        sel_d = sel_q;
        on_d = on_q;
        flag_d = flag_q;
        thr_d = link.limit_threshold_input;
        if (!ready) begin
            // supplies not good: hold handshake flag, ignore input
            on_d = 1'b0;
            flag_d = 1'b1;
            // next toggle lands on output a after the reference returns
            sel_d = 1'b1;
        end else begin
            // handshake: flag drops once when the reference turns good
            if (!rdy_last_q) begin
                flag_d = 1'b0;
            end
            if (rise) begin
                on_d = 1'b1;
                sel_d = ~sel_q;
                flag_d = 1'b0;
            end
            if (!pt) begin
                on_d = 1'b0;
            end
            if (pwm_s_q[1]) begin
                on_d = 1'b0;
            end
            // trip wins over a coincident rising edge: pulse truncated
            if (cl_s_q[1]) begin
                on_d = 1'b0;
                flag_d = 1'b1;
            end
        end
        a_d = on_d & ~sel_d;
        b_d = on_d & sel_d;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pt_last_q <= 1'b0;
            rdy_last_q <= 1'b0;
            sel_q <= 1'b1;
            on_q <= 1'b0;
            flag_q <= 1'b1;
            a_q <= 1'b0;
            b_q <= 1'b0;
            thr_q <= ptp_pkg::LIMIT_THRESHOLD_INPUT_RST;
        end else begin
            pt_last_q <= pt_last_d;
            rdy_last_q <= rdy_last_d;
            sel_q <= sel_d;
            on_q <= on_d;
            flag_q <= flag_d;
            a_q <= a_d;
            b_q <= b_d;
            thr_q <= thr_d;
        end
    end

    assign drive_output_a = a_q;
    assign drive_output_b = b_q;
    assign link.overcurrent_flag_out = flag_q;
    assign limit_threshold_out = thr_q;
endmodule // ptp_device

// ===== logic/ptp_host.sv
// digital controller end: handshake, soft start and pulse generation
`timescale 1ns/100ps
module ptp_host (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    ptp_link_if.host link,
    input wire logic init_done_in,
    input wire logic [15:0] period_cyc_in,
    input wire logic [15:0] max_high_cyc_in,
    input wire logic [2:0] limit_sel_in,
    input wire logic [3:0] limit_allow_in,
    output logic running_out,
    output logic shutdown_out,
    output logic limit_event_out
);
    ptp_pkg::ptp_host_state_t st_q, st_d;
    logic [1:0] flag_s_q;
    logic flag_last_q;
    logic [15:0] cnt_q, cnt_d, high_q, high_d;
    logic [3:0] lim_q, lim_d;
    logic pt_q, pt_d, off_q, off_d, ev_q, ev_d;
    logic [2:0] thr_q;
    logic flag, flag_rise;

    assign flag = flag_s_q[1];
    assign flag_rise = flag & ~flag_last_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        high_d = high_q;
        lim_d = lim_q;
        off_d = off_q;
        pt_d = 1'b0;
        ev_d = 1'b0;
        case (st_q)
            ptp_pkg::PTP_WAIT_READY: begin
                if (init_done_in) begin
                    st_d = ptp_pkg::PTP_WAIT_LOW;
                end
            end
            ptp_pkg::PTP_WAIT_LOW: begin
                if (!flag) begin
                    st_d = ptp_pkg::PTP_RUN;
                    cnt_d = 16'h0000;
                end
            end
            ptp_pkg::PTP_RUN: begin
                // fixed period, duty ramps one cycle per period
                if (cnt_q >= period_cyc_in - 16'h0001) begin
                    cnt_d = 16'h0000;
                    if (high_q < max_high_cyc_in) begin
                        high_d = high_q + 16'h0001;
                    end
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
                // latch off once the allowed count is spent
                if (flag_rise) begin
                    ev_d = 1'b1;
                    if (lim_q >= limit_allow_in) begin
                        off_d = 1'b1;
                    end else begin
                        lim_d = lim_q + 4'h1;
                    end
                end
                pt_d = ~off_d & (cnt_d < high_d);
            end
            default: begin
                st_d = ptp_pkg::PTP_WAIT_READY;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= ptp_pkg::PTP_WAIT_READY;
            flag_s_q <= 2'h3;
            flag_last_q <= 1'b1;
            cnt_q <= 16'h0000;
            high_q <= ptp_pkg::HIGH_CYC_RST;
            lim_q <= ptp_pkg::LIMIT_CNT_RST;
            off_q <= 1'b0;
            pt_q <= 1'b0;
            ev_q <= 1'b0;
            thr_q <= ptp_pkg::LIMIT_THRESHOLD_INPUT_RST;
        end else begin
            st_q <= st_d;
            flag_s_q <= {flag_s_q[0], link.overcurrent_flag_out};
            flag_last_q <= flag;
            cnt_q <= cnt_d;
            high_q <= high_d;
            lim_q <= lim_d;
            off_q <= off_d;
            pt_q <= pt_d;
            ev_q <= ev_d;
            thr_q <= limit_sel_in;
        end
    end

    assign link.pulse_train = pt_q;
    assign link.limit_threshold_input = thr_q;
    assign running_out = pt_q;
    assign shutdown_out = off_q;
    assign limit_event_out = ev_q;
endmodule // ptp_host

// ===== logic/ptp_link_if.sv
// link between the digital controller and the pwm control logic
`timescale 1ns/100ps
interface ptp_link_if;
    logic pulse_train;
    logic overcurrent_flag_out;
    logic [2:0] limit_threshold_input;

    modport device (
        input pulse_train,
        input limit_threshold_input,
        output overcurrent_flag_out
    );
    modport host (
        output pulse_train,
        output limit_threshold_input,
        input overcurrent_flag_out
    );
endinterface

// ===== logic/ptp_pkg.sv
// shared constants and types for the pulse-train push-pull pwm link
package ptp_pkg;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] LIMIT_THRESHOLD_INPUT_W = 2'h3;
    // host soft-start / period defaults, in sys clock cycles
    localparam logic [15:0] PERIOD_CYC_RST = 16'h00c8;
    localparam logic [15:0] HIGH_CYC_RST = 16'h0000;
    localparam logic [3:0] LIMIT_CNT_RST = 4'h0;
    localparam logic [2:0] LIMIT_THRESHOLD_INPUT_RST = 3'h0;

    typedef enum logic [1:0] {
        PTP_WAIT_READY = 2'b00,
        PTP_WAIT_LOW = 2'b01,
        PTP_RUN = 2'b10
    } ptp_host_state_t;
endpackage

// ===== tb/ptp_link_properties.sv
// concurrent checks on the pwm link and the drive outputs
`timescale 1ns/100ps
module ptp_link_properties (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic pulse_train,
    input wire logic overcurrent_flag_out,
    input wire logic ref_good_in,
    input wire logic pwm_trip_in,
    input wire logic current_trip_in,
    input wire logic drive_output_a,
    input wire logic drive_output_b
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic last_a_q;
    // remembers which output fired last; a lost reference restarts at a
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) last_a_q <= 1'b0;
        else if (drive_output_a) last_a_q <= 1'b1;
        else if (drive_output_b || !ref_good_in) last_a_q <= 1'b0;
    end
    not_ready_idle_a: assert property (!ref_good_in [*6] |->
        !drive_output_a && !drive_output_b && overcurrent_flag_out)
        else $error("not ready but drive or flag wrong");
    low_disables_a: assert property (!pulse_train [*6] |->
        !drive_output_a && !drive_output_b) else $error("drive while low");
    trip_cuts_a: assert property (current_trip_in [*6] |->
        overcurrent_flag_out && !drive_output_a && !drive_output_b)
        else $error("current trip not handled");
    pwm_cut_a: assert property (pwm_trip_in [*6] |->
        !drive_output_a && !drive_output_b) else $error("pwm trip ignored");
    rise_drives_a: assert property ($rose(pulse_train) ##1
        (pulse_train && ref_good_in && !pwm_trip_in && !current_trip_in) [*4]
        |-> drive_output_a || drive_output_b) else $error("no pulse");
    flag_holds_a: assert property ((!pulse_train && ref_good_in) [*4] ##0
        overcurrent_flag_out |=> overcurrent_flag_out)
        else $error("flag cleared without rise");
    steer_to_a_a: assert property ($rose(drive_output_a) |->
        !last_a_q) else $error("output a fired twice");
    steer_to_b_a: assert property ($rose(drive_output_b) |->
        last_a_q) else $error("output b out of turn");
    cover property ($rose(drive_output_a));
    cover property ($rose(drive_output_b));
    cover property ($rose(overcurrent_flag_out) && ref_good_in);
    cover property ($fell(overcurrent_flag_out) && !pulse_train);
endmodule // ptp_link_properties

// ===== tb/pulse_train_push_pull_pwm_logic_tb.sv
// self-checking bench joining the controller end and the pwm logic end
`timescale 1ns/100ps
module pulse_train_push_pull_pwm_logic_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic init = 1'b0;
    logic ok = 1'b0;
    logic ptrip = 1'b0;
    logic ctrip = 1'b0;
    logic drv_a, drv_b, run, shut, lev;
    logic [2:0] lim;
    int err_total = 0;
    int n_checks = 0;
    int n_lev = 0;
    ptp_link_if link();
    wire logic [2:0] mon = {link.pulse_train, drv_b, drv_a};
    wire logic flag = link.overcurrent_flag_out;
    initial begin
        forever #5 clk = ~clk;
    end
    ptp_host u_ptp_host (.sys_clk_in(clk), .rst_n_in(rst_n), .link(link),
        .init_done_in(init), .period_cyc_in(16'h0014),
        .max_high_cyc_in(16'h000c), .limit_sel_in(3'h5),
        .limit_allow_in(4'h1), .running_out(run), .shutdown_out(shut),
        .limit_event_out(lev));
    // one count per limit event pulse seen by the controller end
    always @(negedge clk) if (lev === 1'b1) n_lev++;
    ptp_device u_ptp_device (.sys_clk_in(clk), .rst_n_in(rst_n),
        .link(link), .ref_good_in(ok), .pwm_trip_in(ptrip),
        .current_trip_in(ctrip), .drive_output_a(drv_a),
        .drive_output_b(drv_b), .limit_threshold_out(lim));
    ptp_link_properties u_ptp_link_properties (.sys_clk_in(clk),
        .rst_n_in(rst_n), .pulse_train(link.pulse_train),
        .overcurrent_flag_out(flag), .ref_good_in(ok),
        .pwm_trip_in(ptrip), .current_trip_in(ctrip),
        .drive_output_a(drv_a), .drive_output_b(drv_b));
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait on pulse train or a drive output, then compare
    task automatic wait_on(input int sel, input logic lvl);
        for (int i = 0; i < 400 && mon[sel] !== lvl; i++) tick(1);
        chk(mon[sel], lvl);
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    initial begin
        tick(4);
        rst_n = 1'b1;
        tick(8);
        chk(flag, 1'b1);
        chk(mon, 3'h0);
        init = 1'b1;
        tick(20);
        chk(run, 1'b0);
        ok = 1'b1;
        // let the soft-start ramp reach its full high time
        tick(300);
        wait_on(0, 1'b1);
        wait_on(0, 1'b0);
        wait_on(1, 1'b1);
        wait_on(1, 1'b0);
        wait_on(0, 1'b1);
        chk(lim, 3'h5);
        ptrip = 1'b1;
        tick(6);
        chk(drv_a, 1'b0);
        chk(link.pulse_train, 1'b1);
        ptrip = 1'b0;
        wait_on(1, 1'b1);
        ctrip = 1'b1;
        tick(6);
        chk(mon[1:0], 2'h0);
        chk(flag, 1'b1);
        ctrip = 1'b0;
        chk(shut, 1'b0);
        wait_on(2, 1'b0);
        chk(flag, 1'b1);
        wait_on(2, 1'b1);
        tick(5);
        chk(flag, 1'b0);
        wait_on(0, 1'b1);
        ctrip = 1'b1;
        tick(6);
        ctrip = 1'b0;
        tick(10);
        chk(shut, 1'b1);
        chk(16'(n_lev), 16'h0002);
        tick(60);
        chk(mon, 3'h0);
        ok = 1'b0;
        tick(6);
        chk(flag, 1'b1);
        give_verdict();
    end
endmodule // pulse_train_push_pull_pwm_logic_tb
